// *** pcu_pkg.sv ***
// package for the port configuration unit: register map, field layout, types.
// assumes one 250 MHz clock and a 32-bit Avalon-MM register slave.
package pcu_pkg;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] PCU_OFF_MASK     = 8'h00;
    localparam logic [7:0] PCU_OFF_VMAP_A   = 8'h08;
    localparam logic [7:0] PCU_OFF_VMAP_B   = 8'h0c;
    localparam logic [7:0] PCU_OFF_CLKEV    = 8'h04;
    localparam logic [7:0] PCU_OFF_RELOC    = 8'h14;
    localparam logic [7:0] PCU_OFF_EVCTL    = 8'h18;
    localparam logic [7:0] PCU_OFF_PINPORT  = 8'h1c; // target port of pin setup writes
    localparam logic [7:0] PCU_OFF_PINSET   = 8'h40; // 8 pin setup words, 0x40..0x5c
    localparam logic [7:0] PCU_OFF_VPORT    = 8'h80; // 4 vports x 4 regs, 0x80..0xbc

    // ************************************************************
    // reset values and field layout
    // ************************************************************
    localparam logic [7:0] PCU_RST_BYTE     = 8'h00;
    localparam logic [7:0] PCU_RELOC_MASK   = 8'h0f; // bits 7:4 reserved
    localparam logic [7:0] PCU_EVCTL_MASK   = 8'h07; // bits 7:3 reserved
    localparam logic [7:0] PCU_IRQF_MASK    = 8'h03; // flag bits 1:0 only
    localparam int         PCU_NPORT        = 16;
    localparam int         PCU_NVP          = 4;
    localparam int         PCU_BIT_PINSEL   = 7;
    localparam int         PCU_BIT_RTC_SOURCE_OUTPUT_ENABLE   = 6;
    localparam int         PCU_PIN_HI       = 7;
    localparam int         PCU_PIN_LO       = 4;
    localparam int         PCU_PIN_RTC      = 6;

    // ************************************************************
    // port codes (selector order)
    // ************************************************************
    localparam logic [3:0] PCU_PORT_C       = 4'h2;
    localparam logic [3:0] PCU_PORT_D       = 4'h3;
    localparam logic [3:0] PCU_PORT_E       = 4'h4;
    localparam logic [3:0] PCU_PORT_F       = 4'h5;
    localparam logic [3:0] PCU_PORT_H       = 4'h7;
    localparam logic [3:0] PCU_PORT_L       = 4'ha;

    // virtual port register kinds
    typedef enum logic [1:0] {
        PCU_VR_DIR   = 2'b00,
        PCU_VR_OUT   = 2'b01,
        PCU_VR_IN    = 2'b10,
        PCU_VR_FLAGS = 2'b11
    } pcu_vreg_t;

    // routed clock choice
    typedef enum logic [1:0] {
        PCU_CLK_1X = 2'b00,
        PCU_CLK_2X = 2'b01,
        PCU_CLK_4X = 2'b10,
        PCU_CLK_NA = 2'b11
    } pcu_clksel_t;

    // clock/event routing register layout
    typedef struct packed {
        logic        pin_select;
        logic        rtc_out;
        logic [1:0]  event_port;
        pcu_clksel_t clk_choice;
        logic [1:0]  clock_port;
    } pcu_clkev_t;

    // per-port access toward the physical port registers
    typedef struct packed {
        logic       wr;
        logic       rd;
        pcu_vreg_t  reg_kind;
        logic [7:0] wdata;
    } pcu_port_req_t;

    // pin setup broadcast toward all pin setup registers of one port
    typedef struct packed {
        logic [7:0] wr_en;
        logic [7:0] wdata;
    } pcu_pinset_t;

endpackage

// *** pcu_port_config.sv ***
// port configuration unit: multi-pin setup, virtual ports, clock/event routing,
// external bus signal relocation. physical port registers live outside and answer
// combinationally on phys_rdata in the cycle of the request.
//
// Behaviour
// - mask bit n enrolls pin n in a combined pin setup write
// - nonzero mask: pin setup write goes to every masked pin, only those
// - mask clears itself after any pin setup write
// - map A: vport1 selector bits 7:4, vport0 selector bits 3:0
// - map B: vport3 selector bits 7:4, vport2 selector bits 3:0
// - vport dir/out/in/flag access acts as the selected physical port's
// - selector codes 0..15 name ports A..H, J..N, P, Q, R
// - pin select bit moves routed clock/event from pin 7 to pin 4
// - rtc output bit drives rtc source on port C pin 6
// - event field: 00 off, 01 C, 10 D, 11 E
// - clock choice: 00 1x, 01 2x, 10 4x peripheral clock
// - clock port field: 00 off, 01 C, 10 D, 11 E
// - clock wins over event on the same pin
// - address placement: 00 F0-7, 01 E0-7, 10 F4-7, 11 E4-7
// - address placement only acts in four-port bus mode
// - extra address pins carry mode-dependent address slices
// - chip selects on pins 4-7 of H, L, F or E
// - reserved bits read zero and are stored as zero
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module pcu_port_config
    import pcu_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // avalon-mm register slave
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // physical port register access, one strobe set per port
    output pcu_port_req_t [15:0]   phys_req,
    input  wire logic [15:0][7:0]  phys_rdata,
    // pin setup writes toward one port
    output logic [3:0]             pinset_port,
    output pcu_pinset_t            pinset,
    // clock and event sources
    input  wire logic              periph_clk_1x,
    input  wire logic              periph_clk_2x,
    input  wire logic              periph_clk_4x,
    input  wire logic              rtc_clk_src,
    input  wire logic              event_ch0,
    // routed pin functions: [0]=port C, [1]=D, [2]=E, bit = pin
    output logic [2:0][7:0]        route_en,
    output logic [2:0][7:0]        route_val,
    // external bus relocation
    input  wire logic              ebus_four_port,
    input  wire logic [1:0]        ebus_mem_mode,
    input  wire logic [23:8]       ebus_addr,
    input  wire logic [3:0]        ebus_cs,
    output logic [7:0]             reloc_f_en,
    output logic [7:0]             reloc_f_val,
    output logic [7:0]             reloc_e_en,
    output logic [7:0]             reloc_e_val,
    output logic [3:0]             reloc_h_en,
    output logic [3:0]             reloc_h_val,
    output logic [3:0]             reloc_l_en,
    output logic [3:0]             reloc_l_val,
    // state seen by the pin logic
    output logic [7:0]             event_pin_control
);

    // ************************************************************
    // decode helpers
    // ************************************************************
    // maps a 2-bit C/D/E port field to a one-hot of the three routable ports
    function automatic logic [2:0] port_onehot(input logic [1:0] code);
        logic [2:0] oh;
        oh = 3'b000;
        if (code != 2'b00) begin
            oh[code - 2'b01] = 1'b1;
        end
        return oh;
    endfunction

    // vport selector lookup: four nibbles held in two map registers
    function automatic logic [3:0] vp_sel(input logic [7:0] ma, input logic [7:0] mb, input logic [1:0] vp);
        logic [15:0] all;
        all = {mb, ma};
        return all[vp*4 +: 4];
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] vmap_a_r, vmap_a_nxt;
    logic [7:0] vmap_b_r, vmap_b_nxt;
    logic [7:0] clkev_r, clkev_nxt;
    logic [7:0] reloc_r, reloc_nxt;
    logic [7:0] evctl_r, evctl_nxt;
    logic [3:0] pinset_port_r, pinset_port_nxt;
    logic       ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic        acc;
    logic [7:0]  wbyte;
    logic        hit_pinset, hit_vport;
    logic [2:0]  pin_idx;
    logic [1:0]  vp_idx;
    pcu_vreg_t   vp_kind;
    logic [3:0]  vp_port;
    pcu_clkev_t  clkev;

    assign acc        = (avs_read || avs_write) && !ack_r;
    assign wbyte      = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
    assign hit_pinset = (avs_address[7:5] == PCU_OFF_PINSET[7:5]);
    assign hit_vport  = (avs_address[7:6] == PCU_OFF_VPORT[7:6]);
    assign pin_idx    = avs_address[4:2];
    assign vp_idx     = avs_address[5:4];
    assign vp_kind    = pcu_vreg_t'(avs_address[3:2]);
    assign vp_port    = vp_sel(vmap_a_r, vmap_b_r, vp_idx);
    assign clkev      = pcu_clkev_t'(clkev_r);

    // one wait cycle per access: answer comes on the second edge
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata    = rdata_r;

    // ************************************************************
    // register next state
    // ************************************************************
    always_comb begin
        mask_nxt        = mask_r;
        vmap_a_nxt      = vmap_a_r;
        vmap_b_nxt      = vmap_b_r;
        clkev_nxt       = clkev_r;
        reloc_nxt       = reloc_r;
        evctl_nxt       = evctl_r;
        pinset_port_nxt = pinset_port_r;
        ack_nxt         = acc;
        rdata_nxt       = rdata_r;
        if (acc && avs_write) begin
            if (hit_pinset) begin
                mask_nxt = PCU_RST_BYTE;
            end else begin
                unique case (avs_address)
                    PCU_OFF_MASK:   mask_nxt = wbyte;
                    PCU_OFF_VMAP_A: vmap_a_nxt = wbyte;
                    PCU_OFF_VMAP_B: vmap_b_nxt = wbyte;
                    PCU_OFF_CLKEV:  clkev_nxt = wbyte;
                    PCU_OFF_RELOC:  reloc_nxt = wbyte & PCU_RELOC_MASK;
                    PCU_OFF_EVCTL:  evctl_nxt = wbyte & PCU_EVCTL_MASK;
                    PCU_OFF_PINPORT: pinset_port_nxt = wbyte[3:0];
                    default:        ;
                endcase
            end
        end
        if (acc && avs_read) begin
            rdata_nxt = 32'h0000_0000;
            if (hit_vport) begin
                rdata_nxt[7:0] = (vp_kind == PCU_VR_FLAGS) ? (phys_rdata[vp_port] & PCU_IRQF_MASK)
                                                           : phys_rdata[vp_port];
            end else begin
                unique case (avs_address)
                    PCU_OFF_MASK:   rdata_nxt[7:0] = mask_r;
                    PCU_OFF_VMAP_A: rdata_nxt[7:0] = vmap_a_r;
                    PCU_OFF_VMAP_B: rdata_nxt[7:0] = vmap_b_r;
                    PCU_OFF_CLKEV:  rdata_nxt[7:0] = clkev_r;
                    PCU_OFF_RELOC:  rdata_nxt[7:0] = reloc_r;
                    PCU_OFF_EVCTL:  rdata_nxt[7:0] = evctl_r;
                    PCU_OFF_PINPORT: rdata_nxt[3:0] = pinset_port_r;
                    default:        rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask_r        <= PCU_RST_BYTE;
            vmap_a_r      <= PCU_RST_BYTE;
            vmap_b_r      <= PCU_RST_BYTE;
            clkev_r       <= PCU_RST_BYTE;
            reloc_r       <= PCU_RST_BYTE;
            evctl_r       <= PCU_RST_BYTE;
            pinset_port_r <= 4'h0;
            ack_r         <= 1'b0;
            rdata_r       <= 32'h0000_0000;
        end else begin
            mask_r        <= mask_nxt;
            vmap_a_r      <= vmap_a_nxt;
            vmap_b_r      <= vmap_b_nxt;
            clkev_r       <= clkev_nxt;
            reloc_r       <= reloc_nxt;
            evctl_r       <= evctl_nxt;
            pinset_port_r <= pinset_port_nxt;
            ack_r         <= ack_nxt;
            rdata_r       <= rdata_nxt;
        end
    end

    assign pinset_port       = pinset_port_r;
    assign event_pin_control = evctl_r;

    // ************************************************************
    // pin setup broadcast and virtual port forwarding
    // ************************************************************
    // write strobes leave in the access cycle so the target sees exactly one write
    always_comb begin
        pinset.wdata = wbyte;
        pinset.wr_en = 8'h00;
        if (acc && avs_write && hit_pinset) begin
            if (mask_r != 8'h00) begin
                pinset.wr_en = mask_r;
            end else begin
                pinset.wr_en[pin_idx] = 1'b1;
            end
        end
    end

    // every port sees a request only when a vport aimed at it is accessed
    generate
        for (genvar p = 0; p < PCU_NPORT; p++) begin : g_port
            always_comb begin
                phys_req[p].reg_kind = vp_kind;
                phys_req[p].wdata    = wbyte;
                phys_req[p].wr       = acc && avs_write && hit_vport && (vp_port == 4'(p));
                phys_req[p].rd       = acc && avs_read && hit_vport && (vp_port == 4'(p));
            end
        end
    endgenerate

    // ************************************************************
    // clock and event routing
    // ************************************************************
    logic       clk_src;
    logic [2:0] clk_oh, ev_oh;
    logic [2:0] pin_sel;

    always_comb begin
        unique case (clkev.clk_choice)
            PCU_CLK_1X: clk_src = periph_clk_1x;
            PCU_CLK_2X: clk_src = periph_clk_2x;
            PCU_CLK_4X: clk_src = periph_clk_4x;
            default:    clk_src = 1'b0; // unused code drives low
        endcase
    end

    assign clk_oh  = port_onehot(clkev.clock_port);
    assign ev_oh   = port_onehot(clkev.event_port);
    assign pin_sel = clkev.pin_select ? 3'(PCU_PIN_LO) : 3'(PCU_PIN_HI);

    // pure routing: the clock passes through gates, never through a flop
    always_comb begin
        route_en  = '0;
        route_val = '0;
        for (int i = 0; i < 3; i++) begin
            if (clk_oh[i]) begin
                route_en[i][pin_sel]  = 1'b1;
                route_val[i][pin_sel] = clk_src;
            end else if (ev_oh[i]) begin
                route_en[i][pin_sel]  = 1'b1;
                route_val[i][pin_sel] = event_ch0;
            end
        end
        if (clkev.rtc_out) begin
            route_en[0][PCU_PIN_RTC]  = 1'b1;
            route_val[0][PCU_PIN_RTC] = rtc_clk_src;
        end
    end

    // ************************************************************
    // external bus relocation
    // ************************************************************
    logic [7:0] addr_byte;
    logic [1:0] adr_place;
    logic [1:0] cs_place;

    assign adr_place = reloc_r[3:2];
    assign cs_place  = reloc_r[1:0];

    // address slice by memory mode: 0 sdram, 1 sram, 2 sram unlatched
    always_comb begin
        addr_byte = 8'h00;
        if (!adr_place[1]) begin
            unique case (ebus_mem_mode)
                2'b00:   addr_byte = {4'h0, ebus_addr[18:15]};
                2'b01:   addr_byte = ebus_addr[23:16];
                2'b10:   addr_byte = ebus_addr[15:8];
                default: addr_byte = 8'h00;
            endcase
        end else begin
            addr_byte = (ebus_mem_mode == 2'b00) ? {ebus_addr[18:15], 4'h0} : {ebus_addr[19:16], 4'h0};
        end
    end

    always_comb begin
        reloc_f_en  = 8'h00;
        reloc_e_en  = 8'h00;
        reloc_f_val = 8'h00;
        reloc_e_val = 8'h00;
        reloc_h_en  = 4'h0;
        reloc_l_en  = 4'h0;
        reloc_h_val = 4'h0;
        reloc_l_val = 4'h0;
        if (ebus_four_port) begin
            unique case (adr_place)
                2'b00: begin reloc_f_en = 8'hff; reloc_f_val = addr_byte; end
                2'b01: begin reloc_e_en = 8'hff; reloc_e_val = addr_byte; end
                2'b10: begin reloc_f_en = 8'hf0; reloc_f_val = addr_byte; end
                2'b11: begin reloc_e_en = 8'hf0; reloc_e_val = addr_byte; end
            endcase
        end
        unique case (cs_place)
            2'b00: begin reloc_h_en = 4'hf; reloc_h_val = ebus_cs; end
            2'b01: begin reloc_l_en = 4'hf; reloc_l_val = ebus_cs; end
            2'b10: begin reloc_f_en[7:4] = 4'hf; reloc_f_val[7:4] = ebus_cs; end
            2'b11: begin reloc_e_en[7:4] = 4'hf; reloc_e_val[7:4] = ebus_cs; end
        endcase
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_pinset_wr;
        acc && avs_write && hit_pinset;
    endsequence

    property p_mask_enroll;
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && avs_write && avs_address == PCU_OFF_MASK && avs_byteenable[0]) |=> (mask_r == $past(avs_writedata[7:0]));
    endproperty
    a_mask_enroll: assert property (p_mask_enroll) else $error("mask not stored");

    property p_mask_broadcast;
        @(posedge sys_clk) disable iff (!rst_n)
        (s_pinset_wr and (mask_r != 8'h00)) |-> (pinset.wr_en == mask_r);
    endproperty
    a_mask_broadcast: assert property (p_mask_broadcast) else $error("pin setup broadcast wrong");

    property p_mask_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        s_pinset_wr |=> (mask_r == 8'h00);
    endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("mask not cleared");

    property p_vport_alias;
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && avs_read && hit_vport && vp_kind != PCU_VR_FLAGS) |=> (avs_readdata[7:0] == $past(phys_rdata[vp_port]));
    endproperty
    a_vport_alias: assert property (p_vport_alias) else $error("vport read mismatch");

    property p_vport_target;
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && avs_write && hit_vport) |-> phys_req[vp_port].wr;
    endproperty
    a_vport_target: assert property (p_vport_target) else $error("vport write misrouted");

    property p_clock_wins;
        @(posedge sys_clk) disable iff (!rst_n)
        (clkev.clock_port != 2'b00 && clkev.clock_port == clkev.event_port)
            |-> (route_val[clkev.clock_port - 2'b01][pin_sel] == clk_src);
    endproperty
    a_clock_wins: assert property (p_clock_wins) else $error("event overrode clock");

    property p_rtc_pin;
        @(posedge sys_clk) disable iff (!rst_n)
        clkev.rtc_out |-> (route_en[0][PCU_PIN_RTC] && route_val[0][PCU_PIN_RTC] == rtc_clk_src);
    endproperty
    a_rtc_pin: assert property (p_rtc_pin) else $error("rtc not on port c pin 6");

    property p_pin_move;
        @(posedge sys_clk) disable iff (!rst_n)
        (clkev.pin_select && clkev.event_port != 2'b00)
            |-> !route_en[clkev.event_port - 2'b01][PCU_PIN_HI];
    endproperty
    a_pin_move: assert property (p_pin_move) else $error("routed output stayed on pin 7");

    property p_four_port;
        @(posedge sys_clk) disable iff (!rst_n)
        (!ebus_four_port && cs_place[1] == 1'b0) |-> (reloc_f_en == 8'h00 && reloc_e_en == 8'h00);
    endproperty
    a_four_port: assert property (p_four_port) else $error("address placed outside four-port mode");

    property p_reserved_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        (acc && avs_read && avs_address == PCU_OFF_RELOC) |=> (avs_readdata[7:4] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

endmodule

// *** port_configuration_unit_test.sv ***
// testbench for the port configuration unit: register bus scenarios and routed outputs.
// assumes one wait cycle per bus request and combinational physical port answers.
`timescale 1ns/1ns
module port_configuration_unit_test;
    import pcu_pkg::*;
    // ************************************************************
    // design signals and bench state
    // ************************************************************
    logic                 sys_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic [7:0]           adr = 8'h00;
    logic                 rd = 1'b0;
    logic                 wr = 1'b0;
    logic [31:0]          wdat = 32'h0;
    logic [31:0]          rdat;
    logic                 wait_rq;
    pcu_port_req_t [15:0] preq;
    logic [15:0][7:0]     prd = '0;
    pcu_pinset_t          pin;
    logic [2:0][7:0]      ren;
    logic [2:0][7:0]      rval;
    logic                 ev0 = 1'b1;
    logic                 clk1x = 1'b0;
    logic [1:0]           mmode = 2'h1;
    logic [3:0]           pport;
    logic                 four_port = 1'b0;
    logic [23:8]          eadr = 16'hc3a5;
    logic [7:0]           f_en, f_val, e_en, e_val, evctl;
    logic [3:0]           h_en, h_val, l_en, l_val;
    logic [31:0]          q;
    pcu_pinset_t          cap_pin;
    pcu_port_req_t [15:0] cap_req;
    int                   fails = 0, cmp_count = 0, cycles = 0;

    pcu_port_config uut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wait_rq),
        .phys_req(preq), .phys_rdata(prd), .pinset_port(pport), .pinset(pin), .periph_clk_1x(clk1x),
        .periph_clk_2x(1'b1), .periph_clk_4x(1'b1), .rtc_clk_src(1'b1), .event_ch0(ev0), .route_en(ren),
        .route_val(rval), .ebus_four_port(four_port), .ebus_mem_mode(mmode), .ebus_addr(eadr), .ebus_cs(4'h9),
        .reloc_f_en(f_en), .reloc_f_val(f_val), .reloc_e_en(e_en), .reloc_e_val(e_val), .reloc_h_en(h_en),
        .reloc_h_val(h_val), .reloc_l_en(l_en), .reloc_l_val(l_val), .event_pin_control(evctl));

    // ************************************************************
    // clock, timeout and shared tasks
    // ************************************************************
    always #2 sys_clk = ~sys_clk;

    // a hang counts as a mismatch and ends the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus transfer; strobes are caught in the wait cycle, read data at the answer edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        adr <= a;
        wdat <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge sys_clk);
            if (wait_rq === 1'b1) begin
                cap_pin = pin;
                cap_req = preq;
            end
        end while (wait_rq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // reset values and an unmapped read
    task automatic t_reset();
        bus(0, PCU_OFF_CLKEV, 8'h00);
        chk(q, 32'h0);
        bus(0, 8'h30, 8'h00);
        chk(q, 32'h0);
        chk({h_en, h_val}, 32'hf9);
    endtask

    // masked pin setup with the edge bits, then self-clear
    task automatic t_mask();
        bus(1, PCU_OFF_MASK, 8'h81);
        bus(1, PCU_OFF_PINSET + 8'h08, 8'ha5);
        chk(32'(cap_pin), {16'h0, 8'h81, 8'ha5});
        bus(0, PCU_OFF_MASK, 8'h00);
        chk(q, 32'h0);
        bus(1, PCU_OFF_PINPORT, 8'h03);
        chk(pport, 32'h3);
        bus(1, PCU_OFF_PINSET + 8'h1c, 8'h3c);
        chk(32'(cap_pin), 32'h803c);
    endtask

    // virtual ports aliasing C, H, A and R
    task automatic t_vport();
        prd[7] <= 8'h5a;
        prd[0] <= 8'hff;
        bus(1, PCU_OFF_VMAP_A, 8'h72);
        bus(1, PCU_OFF_VMAP_B, 8'hf0);
        bus(0, PCU_OFF_VMAP_B, 8'h00);
        chk(q, 32'hf0);
        bus(1, PCU_OFF_VPORT + 8'h04, 8'h3c);
        chk(32'(cap_req[2]), 32'(pcu_port_req_t'{1'b1, 1'b0, PCU_VR_OUT, 8'h3c}));
        bus(0, PCU_OFF_VPORT + 8'h18, 8'h00);
        chk(q, 32'h5a);
        bus(0, PCU_OFF_VPORT + 8'h2c, 8'h00);
        chk(q, 32'h03);
        bus(1, PCU_OFF_VPORT + 8'h30, 8'h11);
        chk(32'(cap_req[15]), 32'(pcu_port_req_t'{1'b1, 1'b0, PCU_VR_DIR, 8'h11}));
    endtask

    // clock and event routing, overlap, pin 4 and rtc
    task automatic t_route();
        ev0 <= 1'b0;
        bus(1, PCU_OFF_VPORT, 8'hd0);
        chk(32'(cap_req[2]), 32'(pcu_port_req_t'{1'b1, 1'b0, PCU_VR_DIR, 8'hd0}));
        bus(1, PCU_OFF_CLKEV, 8'h15);
        chk({ren[0][7], rval[0][7]}, 32'h3);
        bus(1, PCU_OFF_CLKEV, 8'h01);
        chk({ren[0][7], rval[0][7]}, 32'h2);
        clk1x <= 1'b1;
        @(posedge sys_clk);
        chk(rval[0][7], 32'h1);
        bus(1, PCU_OFF_CLKEV, 8'he9);
        chk({ren[0][4], rval[0][4], ren[1][4], rval[1][4]}, 32'he);
        chk({ren[0][6], rval[0][6]}, 32'h3);
        ev0 <= 1'b1;
        bus(1, PCU_OFF_CLKEV, 8'h3e);
        chk({ren[2][7], rval[2][7], ren[1][7], rval[1][7]}, 32'he);
    endtask

    // bus signal relocation and reserved bits
    task automatic t_reloc();
        bus(1, PCU_OFF_VMAP_B, 8'h45);
        bus(1, PCU_OFF_VPORT + 8'h20, 8'hf0);
        chk(32'(cap_req[5]), 32'(pcu_port_req_t'{1'b1, 1'b0, PCU_VR_DIR, 8'hf0}));
        bus(1, PCU_OFF_VPORT + 8'h30, 8'hff);
        chk(32'(cap_req[4]), 32'(pcu_port_req_t'{1'b1, 1'b0, PCU_VR_DIR, 8'hff}));
        bus(1, PCU_OFF_RELOC, 8'hf1);
        bus(0, PCU_OFF_RELOC, 8'h00);
        chk(q, 32'h01);
        chk({l_en, l_val}, 32'hf9);
        four_port <= 1'b1;
        bus(1, PCU_OFF_RELOC, 8'h06);
        chk({e_en, e_val}, {16'h0, 8'hff, eadr[23:16]});
        chk({f_en[7:4], f_val[7:4]}, 32'hf9);
        mmode <= 2'h2;
        @(posedge sys_clk);
        chk(e_val, {24'h0, eadr[15:8]});
        mmode <= 2'h0;
        bus(1, PCU_OFF_RELOC, 8'h0c);
        chk({e_en, e_val}, {16'h0, 8'hf0, eadr[18:15], 4'h0});
        chk({h_en, h_val}, 32'hf9);
        four_port <= 1'b0;
        @(posedge sys_clk);
        chk(e_en, 32'h0);
        bus(1, PCU_OFF_EVCTL, 8'hff);
        bus(0, PCU_OFF_EVCTL, 8'h00);
        chk(q, 32'h07);
        chk(evctl, 32'h07);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mask();
        t_vport();
        t_route();
        t_reloc();
        print_verdict();
    end
endmodule
